/* File: design/cocc_channel.sv */
// Purpose: Configuration and slip control for one clock output channel
// Assumes: APB slave, zero wait state after setup, pclk is the VCO time base
// Notes:   Reserved bits are stored and read back as written
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module cocc_channel
  import cocc_pkg::*;
#(
  parameter bit IS_DEVICE_CLOCK = 1'b1,
  parameter int ADDR_W = 12,
  parameter int DIV_W = 12,
  parameter int SLIP_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_input_pin,
  input wire logic sync_event_pin,
  input wire logic pulse_gen_event_pin,
  input wire logic pair_clock_pin,
  output logic device_clock_output,
  output logic driver_enable,
  output logic [4:0] fine_delay_applied,
  output logic [4:0] coarse_delay_applied,
  output logic slip_pulse,
  output logic slip_busy
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] chan_ctrl;
  logic [7:0] div_low;
  logic [7:0] div_high;
  logic [7:0] fine_delay_setting;
  logic [7:0] coarse_delay_setting;
  logic [7:0] repeat_slip_count_low;
  logic [7:0] repeat_slip_count_high;
  logic [7:0] output_source_select;
  logic [7:0] idle_and_driver_control;
  logic [9:0] idx;
  logic aligned;
  logic mapped;
  logic setup;
  logic wr;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic fundamental;

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  localparam logic [7:0] RST_CTRL = RST_CHAN_CTRL_BASE | (8'(IS_DEVICE_CLOCK) << CTRL_MULTISLIP_EN);

  // Address decode and read mux
  always_comb
  begin
    mapped = aligned;
    rd_byte = 8'h00;
    if (idx == IDX_STATUS_CMD)
      rd_byte = status_byte;
    else if (idx == IDX_CHAN_CTRL)
      rd_byte = chan_ctrl;
    else if (idx == IDX_DIV_LOW)
      rd_byte = div_low;
    else if (idx == IDX_FINE_DELAY)
      rd_byte = fine_delay_setting;
    else if (idx == IDX_COARSE_DELAY)
      rd_byte = coarse_delay_setting;
    else if (idx == IDX_SLIP_CNT_LOW)
      rd_byte = repeat_slip_count_low;
    else if (idx == IDX_SLIP_CNT_HIGH)
      rd_byte = repeat_slip_count_high;
    else if (idx == IDX_OUT_SOURCE)
      rd_byte = output_source_select;
    else if (idx == IDX_IDLE_DRV)
      rd_byte = idle_and_driver_control;
    else if (idx == IDX_DIV_HIGH)
      rd_byte = div_high;
    else
      mapped = 1'b0;
  end

  // Bus answer: ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Register writes, whole byte stored including reserved bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_ctrl <= RST_CTRL;
      div_low <= RST_DIV_LOW;
      div_high <= RST_DIV_HIGH;
      fine_delay_setting <= RST_FINE;
      coarse_delay_setting <= RST_COARSE;
      repeat_slip_count_low <= RST_SLIP_LOW;
      repeat_slip_count_high <= RST_SLIP_HIGH;
      output_source_select <= RST_SOURCE;
      idle_and_driver_control <= RST_IDLE_DRV;
    end
    else if (wr)
    begin
      if (idx == IDX_CHAN_CTRL)
        chan_ctrl <= pwdata[7:0];
      else if (idx == IDX_DIV_LOW)
        div_low <= pwdata[7:0];
      else if (idx == IDX_FINE_DELAY)
        fine_delay_setting <= pwdata[7:0];
      else if (idx == IDX_COARSE_DELAY)
        coarse_delay_setting <= pwdata[7:0];
      else if (idx == IDX_SLIP_CNT_LOW)
        repeat_slip_count_low <= pwdata[7:0];
      else if (idx == IDX_SLIP_CNT_HIGH)
        repeat_slip_count_high <= pwdata[7:0];
      else if (idx == IDX_OUT_SOURCE)
        output_source_select <= pwdata[7:0];
      else if (idx == IDX_IDLE_DRV)
        idle_and_driver_control <= pwdata[7:0];
      else if (idx == IDX_DIV_HIGH)
        div_high <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_ratio;
  logic [SLIP_W-1:0] slip_count;
  logic chan_en;
  logic multislip_en;
  logic slip_en;
  logic pulse_mode;
  logic [1:0] idle_level;
  logic dyn_drv;
  logic spi_slip;

  assign div_ratio = {div_high[3:0], div_low};
  assign slip_count = {repeat_slip_count_high[3:0], repeat_slip_count_low};
  assign chan_en = chan_ctrl[CTRL_CHAN_EN];
  assign multislip_en = chan_ctrl[CTRL_MULTISLIP_EN];
  assign slip_en = chan_ctrl[CTRL_SLIP_EN];
  assign pulse_mode = (chan_ctrl[CTRL_STARTUP_LO+1:CTRL_STARTUP_LO] == STARTUP_DYNAMIC);
  assign idle_level = idle_and_driver_control[IDLE_LVL_LO+1:IDLE_LVL_LO];
  assign dyn_drv = idle_and_driver_control[DYN_DRV_EN];
  assign spi_slip = wr && (idx == IDX_STATUS_CMD) && pwdata[CMD_SLIP_REQ];

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_last;
  logic [3:0] pin_rise;

  assign pin_raw = {pair_clock_pin, pulse_gen_event_pin, sync_event_pin, general_input_pin};

  // Two flops per pin, then one more for edges
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_meta[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
          pin_last[i] <= 1'b0;
        end
        else
        begin
          pin_meta[i] <= pin_raw[i];
          pin_sync[i] <= pin_meta[i];
          pin_last[i] <= pin_sync[i];
        end
      end
      assign pin_rise[i] = pin_sync[i] && !pin_last[i];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Slip engine
  // ---------------------------------------------------------------
  cocc_slip_state_t state;
  logic pend_explicit;
  logic pend_auto;
  logic [SLIP_W-1:0] remaining;
  logic new_explicit;
  logic new_auto;
  logic start_multi;
  logic start_single;

  assign new_explicit = pin_rise[0] || spi_slip;
  assign new_auto = pin_rise[1] || pin_rise[2];
  assign start_multi = (state == COCC_IDLE) && slip_en && multislip_en
    && (pend_explicit || pend_auto) && (slip_count != '0);
  assign start_single = (state == COCC_IDLE) && slip_en && !multislip_en
    && pend_explicit;

  // Pending events; a new event wins over consumption
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_explicit <= 1'b0;
      pend_auto <= 1'b0;
    end
    else
    begin
      if (new_explicit)
        pend_explicit <= 1'b1;
      else if (state == COCC_IDLE)
        pend_explicit <= 1'b0;
      if (new_auto)
        pend_auto <= 1'b1;
      else if (state == COCC_IDLE)
        pend_auto <= 1'b0;
    end
  end

  // Repeat counter and state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= COCC_IDLE;
      remaining <= '0;
    end
    else
    begin
      case (state)
        COCC_IDLE:
        begin
          if (start_multi)
          begin
            remaining <= slip_count;
            state <= COCC_SLIP;
          end
          else if (start_single)
          begin
            remaining <= SLIP_W'(1);
            state <= COCC_SLIP;
          end
        end
        COCC_SLIP:
        begin
          remaining <= remaining - SLIP_W'(1);
          if (remaining == SLIP_W'(1))
            state <= COCC_IDLE;
        end
        default:
        begin
          state <= COCC_IDLE;
        end
      endcase
    end
  end

  // One slip per VCO cycle while slipping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slip_pulse <= 1'b0;
      slip_busy <= 1'b0;
    end
    else
    begin
      slip_pulse <= (state == COCC_SLIP);
      slip_busy <= (state == COCC_SLIP) || start_multi || start_single;
    end
  end

  assign status_byte = {5'h00, pend_explicit || pend_auto, fundamental, slip_busy};

  // ---------------------------------------------------------------
  // Divider, delays and output path
  // ---------------------------------------------------------------
  logic div_out;
  logic fund_toggle;
  logic pulse_active;
  logic next_out;

  cocc_divider #(
    .DIV_W(DIV_W)
  ) u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .ratio(div_ratio),
    .run(chan_en),
    .slip(state == COCC_SLIP),
    .div_out(div_out),
    .fundamental(fundamental)
  );

  // Delay codes: out-of-range values keep the previous setting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fine_delay_applied <= RST_FINE[4:0];
      coarse_delay_applied <= RST_COARSE[4:0];
    end
    else
    begin
      if (fine_delay_setting[4:0] <= FINE_MAX_CODE)
        fine_delay_applied <= fine_delay_setting[4:0];
      if (coarse_delay_setting[4:0] <= COARSE_MAX_CODE)
        coarse_delay_applied <= coarse_delay_setting[4:0];
    end
  end

  // Fundamental stand-in and pulse activity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fund_toggle <= 1'b0;
      pulse_active <= 1'b0;
    end
    else
    begin
      fund_toggle <= chan_en && !fund_toggle;
      if (pin_rise[2])
        pulse_active <= 1'b1;
      else if (!pin_sync[2])
        pulse_active <= 1'b0;
    end
  end

  // Source mux with idle forcing
  always_comb
  begin
    case (output_source_select[1:0])
      SRC_DIVIDER: next_out = div_out;
      SRC_ANALOG_DELAY: next_out = div_out;
      SRC_PAIR: next_out = pin_sync[3];
      SRC_FUNDAMENTAL: next_out = fund_toggle;
      default: next_out = div_out;
    endcase
    if (pulse_mode && (idle_level == IDLE_FORCE_LOW) && !pulse_active)
      next_out = 1'b0;
  end

  // Registered output and driver enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_clock_output <= 1'b0;
      driver_enable <= 1'b0;
    end
    else
    begin
      device_clock_output <= next_out && chan_en;
      if (pulse_mode && dyn_drv)
        driver_enable <= chan_en && pulse_active;
      else
        driver_enable <= chan_en;
    end
  end

endmodule
`default_nettype wire

/* File: include/cocc_pkg.sv */
// Purpose: Shared constants for one clock output channel configuration block
// Assumes: 8-bit registers, one per aligned 32-bit APB word at index * 4
// Notes:   Register indices are kept as printed; byte address is index * 4
package cocc_pkg;

  // Register indices
  localparam logic [9:0] IDX_STATUS_CMD = 10'h0c7;
  localparam logic [9:0] IDX_CHAN_CTRL = 10'h0c8;
  localparam logic [9:0] IDX_DIV_LOW = 10'h0c9;
  localparam logic [9:0] IDX_FINE_DELAY = 10'h0cb;
  localparam logic [9:0] IDX_COARSE_DELAY = 10'h0cc;
  localparam logic [9:0] IDX_SLIP_CNT_LOW = 10'h0cd;
  localparam logic [9:0] IDX_SLIP_CNT_HIGH = 10'h0ce;
  localparam logic [9:0] IDX_OUT_SOURCE = 10'h0cf;
  localparam logic [9:0] IDX_IDLE_DRV = 10'h0d0;
  localparam logic [9:0] IDX_DIV_HIGH = 10'h0e8;

  // Channel control field positions
  localparam int CTRL_CHAN_EN = 0;
  localparam int CTRL_MULTISLIP_EN = 1;
  localparam int CTRL_STARTUP_LO = 2;
  localparam int CTRL_SLIP_EN = 5;
  localparam int CTRL_SYNC_EN = 6;

  // Idle and driver control field positions
  localparam int IDLE_LVL_LO = 6;
  localparam int DYN_DRV_EN = 5;

  // Command register: write one to request a slip
  localparam int CMD_SLIP_REQ = 0;

  // Codes
  localparam logic [1:0] STARTUP_DYNAMIC = 2'h3;
  localparam logic [1:0] IDLE_NORMAL = 2'h0;
  localparam logic [1:0] IDLE_FORCE_LOW = 2'h2;
  localparam logic [1:0] SRC_DIVIDER = 2'h0;
  localparam logic [1:0] SRC_ANALOG_DELAY = 2'h1;
  localparam logic [1:0] SRC_PAIR = 2'h2;
  localparam logic [1:0] SRC_FUNDAMENTAL = 2'h3;

  // Delay limits and step sizes
  localparam logic [4:0] FINE_MAX_CODE = 5'h17;
  localparam logic [4:0] COARSE_MAX_CODE = 5'h11;
  localparam int FINE_STEP_PS = 25;
  localparam int COARSE_STEP_HALF_VCO = 1;

  // Reset values
  localparam logic [7:0] RST_CHAN_CTRL_BASE = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h04;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_FINE = 8'h00;
  localparam logic [7:0] RST_COARSE = 8'h00;
  localparam logic [7:0] RST_SLIP_LOW = 8'h00;
  localparam logic [7:0] RST_SLIP_HIGH = 8'h00;
  localparam logic [7:0] RST_SOURCE = 8'h00;
  localparam logic [7:0] RST_IDLE_DRV = 8'h00;

  // Slip engine states
  typedef enum logic [1:0] {
    COCC_IDLE = 2'b01,
    COCC_SLIP = 2'b10
  } cocc_slip_state_t;

endpackage

/* File: design/cocc_divider.sv */
// Purpose: Channel divider counter with one-cycle slip
// Assumes: One clock edge stands for one VCO cycle
// Notes:   Ratio 0 or 1 passes the fundamental through
`timescale 1ns/1ns
`default_nettype none
module cocc_divider
  import cocc_pkg::*;
#(
  parameter int DIV_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] ratio,
  input wire logic run,
  input wire logic slip,
  output logic div_out,
  output logic fundamental
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic pass;

  assign pass = (ratio <= DIV_W'(1));

  // Next count; a slip holds the count for one cycle
  always_comb
  begin
    next_cnt = cnt;
    if (!run || pass)
    begin
      next_cnt = '0;
    end
    else if (!slip)
    begin
      next_cnt = (cnt >= ratio - DIV_W'(1)) ? '0 : cnt + DIV_W'(1);
    end
  end

  // Counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // Output: high for the first half of each period, toggles in pass mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_out <= 1'b0;
    else if (!run)
      div_out <= 1'b0;
    else if (pass)
      div_out <= ~div_out;
    else
      div_out <= (next_cnt < (ratio >> 1));
  end

  // Fundamental pass-through flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fundamental <= 1'b0;
    else
      fundamental <= pass;
  end

endmodule
`default_nettype wire

/* File: verif/cocc_channel_asserts.sv */
// Purpose: Port checks for the channel configuration block
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound onto every cocc_channel instance
`timescale 1ns/1ns
`default_nettype none
module cocc_channel_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] fine_delay_applied,
  input wire logic [4:0] coarse_delay_applied,
  input wire logic slip_pulse,
  input wire logic slip_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer timing and data shape
  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no answer after setup");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single)
    else $error("answer held too long");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h0000_00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
  property p_err_with_ready;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without answer or with data");
  // Applied delay codes stay in range
  property p_fine_range;
    fine_delay_applied <= 5'h17;
  endproperty
  a_fine_range: assert property (p_fine_range)
    else $error("fine code out of range");
  property p_coarse_range;
    coarse_delay_applied <= 5'h11;
  endproperty
  a_coarse_range: assert property (p_coarse_range)
    else $error("coarse code out of range");
  // Slip burst framing
  property p_busy_first;
    $rose(slip_pulse) |-> $past(slip_busy);
  endproperty
  a_busy_first: assert property (p_busy_first)
    else $error("slip pulse before busy");
  property p_busy_lead;
    $rose(slip_busy) |=> slip_pulse;
  endproperty
  a_busy_lead: assert property (p_busy_lead)
    else $error("no slip pulse after busy");
endmodule
bind cocc_channel cocc_channel_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fine_delay_applied(fine_delay_applied), .coarse_delay_applied(coarse_delay_applied),
  .slip_pulse(slip_pulse), .slip_busy(slip_busy));
`default_nettype wire

/* File: verif/cocc_channel_tb_top.sv */
// Purpose: Self-checking bench for the channel configuration block
// Assumes: Zero wait APB slave, byte address is index times four
// Notes:   Transfer notes queued by the driver, checked by a monitor
`timescale 1ns/1ns
`default_nettype none
module cocc_channel_tb_top;
  import cocc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, device_clock_output, driver_enable, slip_pulse, slip_busy;
  logic general_input_pin = 0, sync_event_pin = 0, pulse_gen_event_pin = 0;
  logic pair_clock_pin = 0;
  logic [4:0] fine_delay_applied, coarse_delay_applied;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  logic [9:0] regs [0:8] = '{IDX_CHAN_CTRL, IDX_DIV_LOW, IDX_FINE_DELAY, IDX_COARSE_DELAY,
    IDX_SLIP_CNT_LOW, IDX_SLIP_CNT_HIGH, IDX_OUT_SOURCE, IDX_IDLE_DRV, IDX_DIV_HIGH};
  logic [7:0] rst [0:8] = '{8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] codes [0:2] = '{8'h05, 8'h18, 8'h17};
  logic [7:0] cexp [0:2] = '{8'h05, 8'h05, 8'h17};
  logic [7:0] ccodes [0:2] = '{8'h11, 8'h32, 8'h0a};
  logic [7:0] ccexp [0:2] = '{8'h11, 8'h11, 8'h0a};
  logic [7:0] d, prev;
  int fail_count = 0, tests_run = 0, pulses = 0, seed = 52;
  cocc_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .general_input_pin(general_input_pin),
    .sync_event_pin(sync_event_pin), .pulse_gen_event_pin(pulse_gen_event_pin),
    .pair_clock_pin(pair_clock_pin), .device_clock_output(device_clock_output),
    .driver_enable(driver_enable), .fine_delay_applied(fine_delay_applied),
    .coarse_delay_applied(coarse_delay_applied), .slip_pulse(slip_pulse),
    .slip_busy(slip_busy));
  // Clock, paired clock and slip pulse counter
  always #2 pclk = ~pclk;
  always @(posedge pclk) pair_clock_pin <= ~pair_clock_pin;
  always @(posedge pclk) if (slip_pulse === 1'b1) pulses++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; note queued for the monitor
  task automatic apb(input logic [11:0] a, input logic wr, input logic [3:0] st,
                     input logic [7:0] wd, input logic [7:0] e, input logic er);
    exp_q.push_back({wr, er, 24'h0000_00, e});
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'($random(seed)), wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic w(input logic [9:0] i, input logic [7:0] v);
    apb({i, 2'b00}, 1'b1, 4'h1, v, 8'h00, 1'b0);
  endtask
  task automatic r(input logic [9:0] i, input logic [7:0] v);
    apb({i, 2'b00}, 1'b0, 4'h1, 8'h00, v, 1'b0);
  endtask
  // Trigger one slip source and count pulses of the burst
  task automatic slip_run(input int kind, input int exp);
    int n;
    n = 0;
    pulses = 0;
    if (kind == 0) w(IDX_STATUS_CMD, 8'h01);
    general_input_pin <= (kind == 1);
    sync_event_pin <= (kind == 2);
    pulse_gen_event_pin <= (kind == 3);
    repeat (8) @(posedge pclk);
    {general_input_pin, sync_event_pin, pulse_gen_event_pin} <= 3'b000;
    while (slip_busy === 1'b1 && n++ < 5000) @(posedge pclk);
    repeat (4) @(posedge pclk);
    check(pulses, exp);
  endtask
  task automatic toggles;
    repeat (6) @(negedge pclk);
    repeat (4)
    begin
      prev = device_clock_output;
      @(negedge pclk);
      check(device_clock_output, ~prev & 8'h01);
    end
    @(posedge pclk);
  endtask
  // Monitor: compare each answer with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      note = exp_q.pop_front();
      check(pslverr, note[32]);
      if (!note[33]) check(prdata, note[31:0]);
    end
  initial
  begin
    #200000;
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) r(regs[i], rst[i]);
    for (int i = 1; i < 9; i++)
    begin
      d = 8'($random(seed));
      w(regs[i], d);
      r(regs[i], d);
    end
    apb({IDX_DIV_HIGH, 2'b00}, 1'b1, 4'h0, ~d, 8'h00, 1'b0);
    r(IDX_DIV_HIGH, d);
    apb({10'h0ca, 2'b00}, 1'b0, 4'h1, 8'h00, 8'h00, 1'b1);
    apb({IDX_FINE_DELAY, 2'b01}, 1'b1, 4'h1, 8'h07, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      w(IDX_FINE_DELAY, codes[i]);
      w(IDX_COARSE_DELAY, ccodes[i]);
      repeat (4) @(posedge pclk);
      check(fine_delay_applied, cexp[i]);
      check(coarse_delay_applied, ccexp[i]);
    end
    w(IDX_CHAN_CTRL, 8'h21);
    slip_run(0, 1);
    slip_run(1, 1);
    slip_run(2, 0);
    w(IDX_SLIP_CNT_LOW, 8'h02);
    w(IDX_SLIP_CNT_HIGH, 8'h01);
    w(IDX_CHAN_CTRL, 8'h23);
    for (int k = 0; k < 4; k++) slip_run(k, 258);
    w(IDX_CHAN_CTRL, 8'h03);
    slip_run(0, 0);
    w(IDX_CHAN_CTRL, 8'h01);
    w(IDX_OUT_SOURCE, {6'h00, SRC_FUNDAMENTAL});
    toggles();
    w(IDX_OUT_SOURCE, {6'h00, SRC_DIVIDER});
    w(IDX_DIV_LOW, 8'h01);
    w(IDX_DIV_HIGH, 8'h00);
    toggles();
    for (int s = 1; s < 3; s++)
    begin
      w(IDX_OUT_SOURCE, 8'(s));
      toggles();
    end
    w(IDX_CHAN_CTRL, 8'h0d);
    w(IDX_IDLE_DRV, 8'h00);
    toggles();
    w(IDX_IDLE_DRV, 8'h80);
    repeat (8) @(posedge pclk);
    check(device_clock_output, 0);
    check(driver_enable, 1);
    w(IDX_CHAN_CTRL, 8'h0c);
    repeat (8) @(posedge pclk);
    check(driver_enable, 0);
    w(IDX_CHAN_CTRL, 8'h0d);
    w(IDX_IDLE_DRV, 8'ha0);
    repeat (8) @(posedge pclk);
    check(driver_enable, 0);
    check(device_clock_output, 0);
    pulse_gen_event_pin <= 1'b1;
    toggles();
    check(driver_enable, 1);
    pulse_gen_event_pin <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
